// ==== fsp_pkg.sv ====
// package: state codes, gate carriers and mapping index constants
package fsp_pkg;

  // communication states, one-hot
  typedef enum logic [3:0] {
    FSP_INIT   = 4'h1,
    FSP_PREOP  = 4'h2,
    FSP_SAFEOP = 4'h4,
    FSP_OP     = 4'h8
  } fsp_state_t;

  // requested-state codes carried on the request port
  localparam logic [1:0] FSP_REQ_INIT = 2'h0;
  localparam logic [1:0] FSP_REQ_PREOP = 2'h1;
  localparam logic [1:0] FSP_REQ_SAFEOP = 2'h2;
  localparam logic [1:0] FSP_REQ_OP = 2'h3;

  // mailbox protocol codes; only the object-dictionary one is served
  localparam logic [3:0] FSP_MBX_COE = 4'h3;

  // mapping index ranges
  localparam logic [15:0] FSP_RX_LO = 16'h1600;
  localparam logic [15:0] FSP_RX_HI = 16'h17ff;
  localparam logic [15:0] FSP_TX_LO = 16'h1a00;
  localparam logic [15:0] FSP_TX_HI = 16'h1bff;
  localparam logic [15:0] FSP_RX_VAR = 16'h1600;
  localparam logic [15:0] FSP_RX_FIX_LO = 16'h1701;
  localparam logic [15:0] FSP_RX_FIX_HI = 16'h1705;
  localparam logic [15:0] FSP_TX_VAR = 16'h1a00;
  localparam logic [15:0] FSP_TX_FIX_LO = 16'h1b01;
  localparam logic [15:0] FSP_TX_FIX_HI = 16'h1b04;

  // state and data word reset values
  localparam fsp_state_t FSP_STATE_RST = FSP_INIT;
  localparam logic [31:0] FSP_DATA_RST = 32'h0000_0000;

  // traffic gates for the current state
  typedef struct packed {
    logic reg_ok;   // slave controller register access
    logic sdo_ok;   // mailbox service data
    logic tx_ok;    // transmit process data sent
    logic rx_ok;    // received process data acted on
  } fsp_gate_t;

  // classification of one mapping index
  typedef struct packed {
    logic is_rx;
    logic is_tx;
    logic is_var;
    logic is_fix;
    logic is_avail;
  } fsp_map_t;

endpackage : fsp_pkg

// ==== fsp_core.sv ====
// top: communication state sequencer, traffic gating and mapping classifier
// Overview of operation
// - exactly four states: init, preop, safeop, op
// - upward moves step one state at a time
// - from op, any lower state directly
// - init: register access only, no application traffic
// - preop: mailbox service data only
// - safeop: transmit data and service data only
// - op: all process data valid, mailbox too
// - commands in via receive, drive status out via transmit
// - classify indices as receive or transmit range
// - six receive, five transmit; first ones variable
// - process data per cycle, mailbox on request
// - mailbox serves only object-dictionary protocol
`timescale 1ns/1ps
module fsp_core
  import fsp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  // state change request from the master
  input wire logic i_req_valid,
  input wire logic [1:0] i_req_state,
  input wire logic i_err_clear,
  // mailbox request
  input wire logic i_mbx_valid,
  input wire logic [3:0] i_mbx_proto,
  // process data traffic
  input wire logic i_cycle_tick,
  input wire logic i_rx_valid,
  input wire logic [31:0] i_rx_data,
  input wire logic [31:0] i_tx_status,
  // register access by the master
  input wire logic i_reg_valid,
  // mapping index lookup
  input wire logic [15:0] i_map_index,
  output logic [3:0] o_state,
  output logic o_req_ack,
  output logic o_trans_err,
  output fsp_gate_t o_gate,
  output logic o_reg_ok,
  output logic o_mbx_accept,
  output logic o_mbx_reject,
  output logic o_cmd_valid,
  output logic [31:0] o_cmd_data,
  output logic o_tx_valid,
  output logic [31:0] o_tx_data,
  output fsp_map_t o_map
);

  // state and request decode
  fsp_state_t state;
  fsp_state_t next_state;
  fsp_state_t req_target;
  logic req_legal;
  logic req_skip;
  logic req_take;
  logic skip_take;
  // registered answers
  logic trans_err;
  logic req_ack;
  logic mbx_accept;
  logic mbx_reject;
  logic cmd_valid;
  logic [31:0] cmd_data;
  logic tx_valid;
  logic [31:0] tx_data;
  // decoded strobes for the traffic paths
  logic mbx_proto_ok;
  logic mbx_served;
  logic mbx_take;
  logic mbx_refuse;
  logic cmd_take;
  logic tx_take;
  fsp_map_t map_class;
  fsp_gate_t gate;

  // decode a range check used for several index windows
  function automatic logic in_range(input logic [15:0] idx,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (idx >= lo) && (idx <= hi);
  endfunction : in_range

  // decode a requested-state code to a one-hot state
  function automatic fsp_state_t code_to_state(input logic [1:0] code);
    case (code)
      FSP_REQ_INIT: code_to_state = FSP_INIT;
      FSP_REQ_PREOP: code_to_state = FSP_PREOP;
      FSP_REQ_SAFEOP: code_to_state = FSP_SAFEOP;
      default: code_to_state = FSP_OP;
    endcase
  endfunction : code_to_state

  // the only upward target reachable from each state
  function automatic fsp_state_t step_up(input fsp_state_t s);
    case (s)
      FSP_INIT: step_up = FSP_PREOP;
      FSP_PREOP: step_up = FSP_SAFEOP;
      default: step_up = FSP_OP;
    endcase
  endfunction : step_up

  assign req_target = code_to_state(i_req_state);

  // a request only counts in the cycle its strobe is high
  assign req_take = i_req_valid && req_legal;
  assign skip_take = i_req_valid && req_skip;

  // legality: same state, one step up, or any move down
  // the one-hot codes grow with the state, so a plain compare orders them
  always_comb
  begin
    req_legal = 1'b0;
    req_skip = 1'b0;
    case (state)
      FSP_INIT, FSP_PREOP, FSP_SAFEOP, FSP_OP:
      begin
        if (req_target <= state)
          req_legal = 1'b1;
        else if (req_target == step_up(state))
          req_legal = 1'b1;
        else
          req_skip = 1'b1;
      end
      default:
      begin
        req_legal = 1'b0;
        req_skip = 1'b0;
      end
    endcase
  end

  // next state: illegal requests leave the state untouched
  always_comb
  begin
    next_state = state;
    case (state)
      FSP_INIT, FSP_PREOP, FSP_SAFEOP, FSP_OP:
      begin
        if (req_take)
          next_state = req_target;
      end
      default: next_state = FSP_STATE_RST;
    endcase
  end

  // state register, four legal codes only
  // a corrupted code is pulled back to init by the next-state default
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      state <= FSP_STATE_RST;
    else
      state <= next_state;
  end

  // sticky error: a new skip in the clear cycle wins over the clear
  // the master polls this flag, so it stands until it is cleared
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      trans_err <= 1'b0;
    else if (skip_take)
      trans_err <= 1'b1;
    else if (i_err_clear)
      trans_err <= 1'b0;
  end

  // acknowledge a legal request one cycle after it is taken
  // a refused request gives no ack; the error flag says why
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      req_ack <= 1'b0;
    else
      req_ack <= req_take;
  end

  // traffic gates per state; init only lets register access through
  // every traffic path below is closed while its gate bit is low
  always_comb
  begin
    gate = '0;
    case (state)
      FSP_INIT: gate.reg_ok = 1'b1;
      FSP_PREOP:
      begin
        gate.reg_ok = 1'b1;
        gate.sdo_ok = 1'b1;
      end
      FSP_SAFEOP:
      begin
        gate.reg_ok = 1'b1;
        gate.sdo_ok = 1'b1;
        gate.tx_ok = 1'b1;
      end
      FSP_OP:
      begin
        gate = '1;
      end
      default: gate = '0;
    endcase
  end

  // mailbox decode: served outside init and for one protocol only
  // a foreign protocol is refused, not dropped, so the master sees why
  assign mbx_proto_ok = (i_mbx_proto == FSP_MBX_COE);
  assign mbx_served = gate.sdo_ok && mbx_proto_ok;
  assign mbx_take = i_mbx_valid && mbx_served;
  assign mbx_refuse = i_mbx_valid && !mbx_served;

  // mailbox answers on request only, one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mbx_accept <= 1'b0;
      mbx_reject <= 1'b0;
    end
    else
    begin
      mbx_accept <= mbx_take;
      mbx_reject <= mbx_refuse;
    end
  end

  // process data strobes: one transfer per communication period tick
  assign cmd_take = i_cycle_tick && i_rx_valid && gate.rx_ok;
  assign tx_take = i_cycle_tick && gate.tx_ok;

  // receive path: commands taken once per cycle tick, only in op
  // data held between ticks so the drive sees a stable command
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cmd_valid <= 1'b0;
      cmd_data <= FSP_DATA_RST;
    end
    else
    begin
      cmd_valid <= cmd_take;
      if (cmd_take)
        cmd_data <= i_rx_data;
    end
  end

  // transmit path: drive status reported each cycle tick from safeop
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tx_valid <= 1'b0;
      tx_data <= FSP_DATA_RST;
    end
    else
    begin
      tx_valid <= tx_take;
      if (tx_take)
        tx_data <= i_tx_status;
    end
  end

  // mapping index classifier; registered so the answer is a flop
  // the two windows do not overlap, so at most one of rx and tx is set
  assign map_class.is_rx =
    in_range(i_map_index, FSP_RX_LO, FSP_RX_HI);
  assign map_class.is_tx =
    in_range(i_map_index, FSP_TX_LO, FSP_TX_HI);
  assign map_class.is_var = (i_map_index == FSP_RX_VAR) ||
                            (i_map_index == FSP_TX_VAR);
  assign map_class.is_fix =
    in_range(i_map_index, FSP_RX_FIX_LO, FSP_RX_FIX_HI) ||
    in_range(i_map_index, FSP_TX_FIX_LO, FSP_TX_FIX_HI);
  assign map_class.is_avail = map_class.is_var || map_class.is_fix;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_map <= '0;
    else
      o_map <= map_class;
  end

  // outputs; gates are a decode of the state flop
  // register access is a handshake answer, so it is combinational
  assign o_state = state;
  assign o_req_ack = req_ack;
  assign o_trans_err = trans_err;
  assign o_gate = gate;
  assign o_reg_ok = i_reg_valid && gate.reg_ok;
  assign o_mbx_accept = mbx_accept;
  assign o_mbx_reject = mbx_reject;
  assign o_cmd_valid = cmd_valid;
  assign o_cmd_data = cmd_data;
  assign o_tx_valid = tx_valid;
  assign o_tx_data = tx_data;

endmodule : fsp_core

// ==== fsp_core_assertions.sv ====
// checker: port assertions for the state sequencer and classifier
`timescale 1ns/1ps
module fsp_core_checker
  import fsp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_req_valid,
  input wire logic [1:0] i_req_state,
  input wire logic i_mbx_valid,
  input wire logic [3:0] i_mbx_proto,
  input wire logic i_cycle_tick,
  input wire logic i_rx_valid,
  input wire logic [31:0] i_rx_data,
  input wire logic i_reg_valid,
  input wire logic [15:0] i_map_index,
  input wire logic [3:0] o_state,
  input wire logic o_req_ack,
  input wire logic o_trans_err,
  input wire fsp_gate_t o_gate,
  input wire logic o_reg_ok,
  input wire logic o_mbx_accept,
  input wire logic o_mbx_reject,
  input wire logic o_cmd_valid,
  input wire logic [31:0] o_cmd_data,
  input wire logic o_tx_valid,
  input wire fsp_map_t o_map
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // state index and the highest legal upward target
  wire [1:0] idx = {o_state[3] | o_state[2], o_state[3] | o_state[1]};
  wire [2:0] up_lim = {1'b0, idx} + 3'h1;
  wire skip = i_req_valid && {1'b0, i_req_state} > up_lim;
  wire mbx_ok = o_state != FSP_INIT && i_mbx_proto == FSP_MBX_COE;
  wire rx_hit = i_map_index >= FSP_RX_LO && i_map_index <= FSP_RX_HI;
  wire var_hit = i_map_index == FSP_RX_VAR || i_map_index == FSP_TX_VAR;
  a_state_onehot: assert property ($onehot(o_state))
    else $error("state not one-hot");
  a_skip_refused: assert property (skip |=>
    o_trans_err && !o_req_ack && $stable(o_state)) else $error("skip taken");
  a_legal_taken: assert property (i_req_valid && !skip |=>
    o_req_ack && o_state == 4'h1 << $past(i_req_state)) else $error("no move");
  a_init_gate: assert property (o_state == FSP_INIT |->
    o_gate == 4'h8) else $error("init gate");
  a_preop_gate: assert property (o_state == FSP_PREOP |->
    o_gate == 4'hc) else $error("preop gate");
  a_safeop_gate: assert property (o_state == FSP_SAFEOP |->
    o_gate == 4'he) else $error("safeop gate");
  a_op_gate: assert property (o_state == FSP_OP |->
    o_gate == 4'hf) else $error("op gate");
  a_reg_access: assert property (o_reg_ok == i_reg_valid)
    else $error("register access");
  a_mbx_answer: assert property (i_mbx_valid |=>
    o_mbx_accept == $past(mbx_ok) && o_mbx_reject != $past(mbx_ok))
    else $error("mailbox answer");
  a_cmd_path: assert property (
    i_cycle_tick && i_rx_valid && o_state[3] |=>
    o_cmd_valid && o_cmd_data == $past(i_rx_data)) else $error("cmd");
  a_tx_gate: assert property (i_cycle_tick |=>
    o_tx_valid == $past(o_state[2] | o_state[3])) else $error("tx gate");
  a_map_rx: assert property ($past(i_arst_n) |->
    o_map.is_rx == $past(rx_hit)) else $error("rx class");
  a_map_var: assert property ($past(i_arst_n) |->
    o_map.is_var == $past(var_hit)) else $error("var class");
  c_skip: cover property (skip);
  c_cmd: cover property (o_cmd_valid);
  c_drop: cover property (o_state == FSP_OP ##1 o_state == FSP_PREOP);
endmodule : fsp_core_checker

bind fsp_core fsp_core_checker u_fsp_core_checker (.i_clk, .i_arst_n,
  .i_req_valid, .i_req_state, .i_mbx_valid, .i_mbx_proto, .i_cycle_tick,
  .i_rx_valid, .i_rx_data, .i_reg_valid, .i_map_index, .o_state, .o_req_ack,
  .o_trans_err, .o_gate, .o_reg_ok, .o_mbx_accept, .o_mbx_reject,
  .o_cmd_valid, .o_cmd_data, .o_tx_valid, .o_map);

// ==== fsp_master_model.sv ====
// partner: master station sending period ticks and output data
`timescale 1ns/1ps
module fsp_master_model
  import fsp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  output logic o_tick,
  output logic o_rx_valid,
  output logic [31:0] o_rx_data
);
  logic [2:0] cnt;
  // setup is taken as done before any request; valid data every period
  // data is inverted off the tick so a stale word is never mistaken
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt <= 3'h0;
      o_tick <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_data <= 32'h0;
    end
    else
    begin
      cnt <= cnt + 3'h1;
      o_tick <= cnt == 3'h7;
      o_rx_valid <= cnt == 3'h7;
      o_rx_data <= cnt == 3'h7 ? $urandom : ~o_rx_data;
    end
  end
endmodule : fsp_master_model

// ==== tb_fieldbus_state_pdo_map.sv ====
// testbench: state walk, gating, process data and mapping checks
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module tb_fieldbus_state_pdo_map
  import fsp_pkg::*;
;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_req_valid = 1'b0, i_err_clear = 1'b0;
  logic i_mbx_valid = 1'b0, i_reg_valid = 1'b0, i_cycle_tick, i_rx_valid;
  logic [1:0] i_req_state = 2'h0;
  logic [3:0] i_mbx_proto = 4'h0, o_state;
  logic [15:0] i_map_index = 16'h0;
  logic [31:0] i_rx_data, i_tx_status = 32'h0, o_cmd_data, o_tx_data, e;
  logic o_req_ack, o_trans_err, o_reg_ok, o_mbx_accept, o_mbx_reject;
  logic o_cmd_valid, o_tx_valid, m_err = 1'b0, ok;
  fsp_gate_t o_gate;
  fsp_map_t o_map;
  int m = 0, n_fail = 0, checked = 0;
  logic [31:0] txq[$], cmdq[$];
  logic [15:0] tbl[18] = '{16'h15ff, 16'h1600, 16'h1601, 16'h16ff, 16'h1700,
    16'h1701, 16'h1705, 16'h1706, 16'h17ff, 16'h1800, 16'h19ff, 16'h1a00,
    16'h1b00, 16'h1b01, 16'h1b04, 16'h1b05, 16'h1bff, 16'h1c00};
  fsp_core u_fsp_core (.i_clk, .i_arst_n, .i_req_valid, .i_req_state,
    .i_err_clear, .i_mbx_valid, .i_mbx_proto, .i_cycle_tick, .i_rx_valid,
    .i_rx_data, .i_tx_status, .i_reg_valid, .i_map_index, .o_state,
    .o_req_ack, .o_trans_err, .o_gate, .o_reg_ok, .o_mbx_accept,
    .o_mbx_reject, .o_cmd_valid, .o_cmd_data, .o_tx_valid, .o_tx_data, .o_map);
  fsp_master_model u_fsp_master_model (.i_clk, .i_arst_n,
    .o_tick(i_cycle_tick), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data));
  always #50 i_clk = ~i_clk;
  // reference model of the classifier
  function automatic logic [4:0] mapx(input logic [15:0] x);
    logic r, t, v, f;
    r = x >= 16'h1600 && x <= 16'h17ff;
    t = x >= 16'h1a00 && x <= 16'h1bff;
    v = x == 16'h1600 || x == 16'h1a00;
    f = (x >= 16'h1701 && x <= 16'h1705) || (x >= 16'h1b01 && x <= 16'h1b04);
    return {r, t, v, f, v | f};
  endfunction : mapx
  task automatic req(input logic [1:0] s);
    @(posedge i_clk);
    i_req_valid <= 1'b1;
    i_req_state <= s;
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    // model moves after the edge, so the tick model sees the old state
    #1;
    ok = s <= m + 1;
    if (ok) m = s;
    else m_err = 1'b1;
    `CHK(o_state, 4'h1 << m)
    `CHK(o_req_ack, ok)
    `CHK(o_trans_err, m_err)
    `CHK(o_gate, {1'b1, m > 0, m > 1, m > 2})
  endtask : req
  task automatic clr();
    @(posedge i_clk);
    i_err_clear <= 1'b1;
    @(posedge i_clk);
    i_err_clear <= 1'b0;
    m_err = 1'b0;
    #1;
    `CHK(o_trans_err, 1'b0)
  endtask : clr
  task automatic mbx(input logic [3:0] p);
    @(posedge i_clk);
    i_mbx_valid <= 1'b1;
    i_mbx_proto <= p;
    @(posedge i_clk);
    i_mbx_valid <= 1'b0;
    ok = m > 0 && p == 4'h3;
    #1;
    `CHK(o_mbx_accept, ok)
    `CHK(o_mbx_reject, !ok)
  endtask : mbx
  task automatic mapc(input logic [15:0] x);
    @(posedge i_clk);
    i_map_index <= x;
    @(posedge i_clk);
    #1;
    `CHK(o_map, mapx(x))
  endtask : mapc
  task automatic end_of_test();
    $display("checks %0d fails %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // queue model of process data: a word taken at a tick comes out the
  // next cycle; strobes are compared every cycle so a stray one is seen
  always @(posedge i_clk)
  begin
    i_tx_status <= $urandom;
    i_reg_valid <= 1'($urandom);
    if (i_arst_n)
    begin
      `CHK(o_reg_ok, i_reg_valid)
      `CHK(o_tx_valid, txq.size() != 0)
      `CHK(o_cmd_valid, cmdq.size() != 0)
      if (txq.size() != 0)
      begin
        e = txq.pop_front();
        `CHK(o_tx_data, e)
      end
      if (cmdq.size() != 0)
      begin
        e = cmdq.pop_front();
        `CHK(o_cmd_data, e)
      end
    end
    if (i_cycle_tick && m > 1) txq.push_back(i_tx_status);
    if (i_cycle_tick && i_rx_valid && m == 3) cmdq.push_back(i_rx_data);
  end
  initial
  begin
    #1000000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'h3d9d98e6));
    repeat (4) @(posedge i_clk);
    `CHK(o_state, 4'h1)
    `CHK(o_gate, 4'h8)
    i_arst_n <= 1'b1;
    req(2'h3);
    clr();
    req(2'h2);
    clr();
    $display("skip test done");
    for (int s = 0; s < 4; s++)
    begin
      req(s[1:0]);
      mbx(4'h3);
      mbx(4'($urandom));
      repeat (12) @(posedge i_clk);
    end
    $display("walk test done");
    req(2'h1);
    req(2'h3);
    clr();
    req(2'h0);
    $display("jump test done");
    foreach (tbl[k]) mapc(tbl[k]);
    repeat (8) mapc(16'($urandom));
    $display("map test done");
    end_of_test();
  end
endmodule : tb_fieldbus_state_pdo_map
